// ==== core/table_access_pkg.sv ====
// Constants, register map and types of the forwarding-table access control
// Function
// - After a search ends, bits 29:16 of lookup control show the live-entry count.
// - Software sets lookup bit 7 to launch; hardware clears it when done.
// - Search sets bit 6 per ready entry; reading byte 0x042F clears it.
// - Read-only bit 5 is ready flag OR launch bit 7 clear.
// - Bit 2 set indexes lookup table directly; clear uses the hash.
// - Lookup action bits 1:0: none, write, read, search.
// - Index bits 21:16 address multicast table; bits 19:16 address static table.
// - Software sets static control bit 7 to start; hardware clears it when done.
// - Static control bit 1 selects multicast table (1) or static table (0).
// - Static control bit 0 selects read (1) or write (0).
// - Static table uses all four entry words; multicast uses only word two.
// - Entry word one at 0x0420 serves both lookup and static tables.
// - Lookup operations index from both index registers, data via four entry words.
// - Index is 7-bit filter identifier plus 48-bit address; direct uses bits 11:0.
package table_access_pkg;

  // ==========================================================================
  // Register map (byte addresses, big-endian byte order within a word)
  localparam logic [15:0] ADDR_INDEX_HI = 16'h0410;
  localparam logic [15:0] ADDR_INDEX_LO = 16'h0414;
  localparam logic [15:0] ADDR_LOOKUP_CTRL = 16'h0418;
  localparam logic [15:0] ADDR_STATIC_CTRL = 16'h041C;
  localparam logic [15:0] ADDR_ENTRY1 = 16'h0420;
  localparam logic [15:0] ADDR_ENTRY4_LAST = 16'h042F;

  // ==========================================================================
  // Field positions
  localparam int COUNT_LSB = 16;
  localparam int COUNT_W = 14;
  localparam int START_BIT = 7;
  localparam int READY_BIT = 6;
  localparam int DONE_BIT = 5;
  localparam int DIRECT_BIT = 2;
  localparam int SELECT_BIT = 1;
  localparam int RD_BIT = 0;
  localparam int FID_LSB = 16;
  localparam int FID_W = 7;
  localparam int TIDX_LSB = 16;
  localparam int TIDX_W = 6;
  localparam int STATIC_IDX_W = 4;
  localparam int DIRECT_W = 12;
  localparam int IDX_W = 12;
  localparam int ENTRY_W = 128;
  localparam int MCAST_DEPTH = 64;
  localparam int STATIC_DEPTH = 16;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_WRITE = 2'h1,
    ACT_READ = 2'h2,
    ACT_SEARCH = 2'h3
  } action_t;

  typedef enum logic [1:0] {
    TBL_LOOKUP = 2'h0,
    TBL_STATIC = 2'h1,
    TBL_MCAST = 2'h2
  } table_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SCAN = 3'h1,
    ST_WAIT = 3'h2,
    ST_END = 3'h3
  } state_t;

endpackage

// ==== core/table_port_if.sv ====
// Access port between the control logic and the table storage
interface table_port_if;
  import table_access_pkg::*;
  table_t tbl;
  logic [IDX_W-1:0] idx;
  logic we;
  logic [ENTRY_W-1:0] wdata;
  logic [ENTRY_W-1:0] rdata;
  logic rlive;

  modport engine (output tbl, output idx, output we, output wdata, input rdata, input rlive);
  modport store (input tbl, input idx, input we, input wdata, output rdata, output rlive);
endinterface

// ==== core/table_store.sv ====
// Flip-flop storage for the lookup, static and reserved multicast tables
module table_store
  import table_access_pkg::*;
#(
  parameter int LK_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access port
  table_port_if.store tp
);

  localparam int LK_AW = $clog2(LK_DEPTH);

  if (LK_DEPTH < 2 || LK_DEPTH > 4096 || (LK_DEPTH & (LK_DEPTH - 1)) != 0) begin
    $error("table_store: LK_DEPTH must be a power of two from 2 to 4096");
  end

  logic [ENTRY_W-1:0] lookup_mem [LK_DEPTH];
  logic [LK_DEPTH-1:0] lookup_live;
  logic [ENTRY_W-1:0] static_mem [STATIC_DEPTH];
  logic [31:0] mcast_mem [MCAST_DEPTH];

  wire [LK_AW-1:0] lk_addr = tp.idx[LK_AW-1:0];
  wire [STATIC_IDX_W-1:0] st_addr = tp.idx[STATIC_IDX_W-1:0];
  wire [TIDX_W-1:0] mc_addr = tp.idx[TIDX_W-1:0];

  // ==========================================================================
  // Writes
  always_ff @(posedge clk) begin
    if (rst) begin
      lookup_live <= '0;
    end else if (tp.we && tp.tbl == TBL_LOOKUP) begin
      // An all-zero entry counts as empty, so writing zero deletes it
      lookup_live[lk_addr] <= |tp.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (tp.we) begin
      case (tp.tbl)
        TBL_LOOKUP: lookup_mem[lk_addr] <= tp.wdata;
        TBL_STATIC: static_mem[st_addr] <= tp.wdata;
        TBL_MCAST: mcast_mem[mc_addr] <= tp.wdata[95:64];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Reads
  assign tp.rdata = (tp.tbl == TBL_LOOKUP) ? lookup_mem[lk_addr] :
                    (tp.tbl == TBL_STATIC) ? static_mem[st_addr] :
                    {32'h0000_0000, mcast_mem[mc_addr], 64'h0};
  assign tp.rlive = (tp.tbl == TBL_LOOKUP) && lookup_live[lk_addr];

endmodule

// ==== core/table_access_ctrl.sv ====
// Software access control for the lookup, static and reserved multicast tables
module table_access_ctrl
  import table_access_pkg::*;
#(
  parameter int LK_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte-wide register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Status
  output logic busy
);

  localparam logic [IDX_W-1:0] LAST_PTR = IDX_W'(LK_DEPTH - 1);

  // The storage behind the port needs a power-of-two depth
  if (LK_DEPTH < 2 || LK_DEPTH > 4096 || (LK_DEPTH & (LK_DEPTH - 1)) != 0) begin
    $error("table_access_ctrl: LK_DEPTH must be a power of two from 2 to 4096");
  end

  table_port_if tp ();

  table_store #(.LK_DEPTH(LK_DEPTH)) u_store (
    .clk(clk),
    .rst(rst),
    .tp(tp)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] lane,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = w;
    case (lane)
      2'h0: r[31:24] = d;
      2'h1: r[23:16] = d;
      2'h2: r[15:8] = d;
      default: r[7:0] = d;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] get_byte(input logic [31:0] w, input logic [1:0] lane);
    case (lane)
      2'h0: return w[31:24];
      2'h1: return w[23:16];
      2'h2: return w[15:8];
      default: return w[7:0];
    endcase
  endfunction

  // Folds filter identifier and address into a table index
  // Cheap XOR fold: colliding keys share one slot, there is no chaining
  function automatic logic [IDX_W-1:0] hash_key(input logic [FID_W+47:0] key);
    logic [IDX_W-1:0] h;
    h = '0;
    for (int i = 0; i < FID_W + 48; i++) begin
      h[i % IDX_W] = h[i % IDX_W] ^ key[i];
    end
    return h;
  endfunction

  // ==========================================================================
  // Registers
  logic [31:0] index_hi;
  logic [31:0] index_lo;
  logic [31:0] entry_word [4];
  logic lk_start;
  logic lk_ready;
  logic lk_direct;
  action_t lk_action;
  logic [1:0] lk_spare;
  logic [COUNT_W-1:0] lk_count;
  logic [COUNT_W-1:0] scan_count;
  logic [IDX_W-1:0] scan_ptr;
  logic st_start;
  logic [TIDX_W-1:0] st_index;
  logic [4:0] st_spare;
  logic st_select;
  logic st_read;
  state_t state;
  state_t next_state;

  // ==========================================================================
  // Address decode
  wire [13:0] word_sel = reg_addr[15:2];
  wire [1:0] lane = reg_addr[1:0];
  wire hit_index_hi = word_sel == ADDR_INDEX_HI[15:2];
  wire hit_index_lo = word_sel == ADDR_INDEX_LO[15:2];
  wire hit_lk_ctrl = word_sel == ADDR_LOOKUP_CTRL[15:2];
  wire hit_st_ctrl = word_sel == ADDR_STATIC_CTRL[15:2];
  wire hit_entry = word_sel[13:2] == ADDR_ENTRY1[15:4];
  wire [1:0] entry_sel = word_sel[1:0];
  wire last_byte_read = reg_rd && reg_addr == ADDR_ENTRY4_LAST;
  // Outside a search wait that read changes nothing

  // A control byte is refused while its own launch bit is still set
  // Writing zero to a launch bit therefore cannot abort an operation
  wire wr_lk_low = reg_wr && hit_lk_ctrl && lane == 2'h3 && !lk_start;
  wire wr_st_low = reg_wr && hit_st_ctrl && lane == 2'h3 && !st_start;
  wire wr_st_idx = reg_wr && hit_st_ctrl && lane == 2'h1 && !st_start;

  // ==========================================================================
  // Composed views
  wire lk_done_view = lk_ready || !lk_start;
  wire [31:0] lk_ctrl_view = {2'h0, lk_count, 8'h00, lk_start, lk_ready, lk_done_view,
                              lk_spare, lk_direct, lk_action};
  wire [31:0] st_ctrl_view = {10'h000, st_index, 8'h00, st_start, st_spare, st_select,
                              st_read};
  wire [31:0] read_word = hit_index_hi ? index_hi :
                          hit_index_lo ? index_lo :
                          hit_lk_ctrl ? lk_ctrl_view :
                          hit_st_ctrl ? st_ctrl_view :
                          hit_entry ? entry_word[entry_sel] : RST_WORD;

  // Lookup key: filter identifier plus the full 48-bit address
  wire [FID_W+47:0] lk_key = {index_hi[FID_LSB+FID_W-1:FID_LSB], index_hi[15:0],
                              index_lo};
  wire [IDX_W-1:0] lk_index = lk_direct ? index_lo[DIRECT_W-1:0] :
                                          hash_key(lk_key);

  // ==========================================================================
  // Operation dispatch; lookup takes priority when both are pending
  // A static access waits behind a running search instead of taking its port
  wire lk_go = state == ST_IDLE && lk_start;
  wire st_go = state == ST_IDLE && st_start && !lk_start;
  wire lk_do_write = lk_go && lk_action == ACT_WRITE;
  wire lk_do_read = lk_go && lk_action == ACT_READ;
  wire lk_do_search = lk_go && lk_action == ACT_SEARCH;
  wire lk_do_none = lk_go && lk_action == ACT_NONE;
  wire st_is_mcast = st_select;
  wire st_do_write = st_go && !st_read;
  wire st_do_read = st_go && st_read;
  wire scan_hit = state == ST_SCAN && tp.rlive;
  wire scan_last = scan_ptr == LAST_PTR;

  assign tp.tbl = (state != ST_IDLE || lk_start) ? TBL_LOOKUP :
                  st_is_mcast ? TBL_MCAST : TBL_STATIC;
  assign tp.idx = state == ST_SCAN ? scan_ptr :
                  lk_start ? lk_index :
                  st_is_mcast ? IDX_W'(st_index) :
                  IDX_W'(st_index[STATIC_IDX_W-1:0]);
  assign tp.we = lk_do_write || st_do_write;
  // Word one travels in the top bits of the 128-bit entry
  assign tp.wdata = {entry_word[0], entry_word[1], entry_word[2],
                     entry_word[3]};

  // ==========================================================================
  // Search sequencer
  // One slot per cycle, so an empty table scans in LK_DEPTH + 1 cycles
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (lk_do_search) next_state = ST_SCAN;
      ST_SCAN: begin
        if (tp.rlive) begin
          next_state = ST_WAIT;
        end else if (scan_last) begin
          next_state = ST_END;
        end
      end
      ST_WAIT: begin
        if (last_byte_read) begin
          next_state = scan_last ? ST_END : ST_SCAN;
        end
      end
      ST_END: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      scan_ptr <= '0;
      scan_count <= '0;
    end else begin
      state <= next_state;
      if (lk_do_search) begin
        scan_ptr <= '0;
        scan_count <= '0;
      end else if (scan_hit) begin
        scan_count <= scan_count + 1'b1;
      end else if ((state == ST_SCAN && !scan_last) ||
                   (state == ST_WAIT && last_byte_read && !scan_last)) begin
        scan_ptr <= scan_ptr + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Lookup control register
  always_ff @(posedge clk) begin
    if (rst) begin
      lk_start <= 1'b0;
      lk_ready <= 1'b0;
      lk_direct <= 1'b0;
      lk_action <= ACT_NONE;
      lk_spare <= 2'h0;
      lk_count <= '0;
    end else begin
      if (wr_lk_low) begin
        lk_start <= reg_wdata[START_BIT];
        lk_direct <= reg_wdata[DIRECT_BIT];
        lk_action <= action_t'(reg_wdata[1:0]);
        lk_spare <= reg_wdata[4:3];
      end else if (lk_do_write || lk_do_read || lk_do_none || state == ST_END) begin
        lk_start <= 1'b0;
      end
      // Set only while scanning and cleared only while waiting, so they never meet
      if (scan_hit) begin
        lk_ready <= 1'b1;
      end else if (state == ST_WAIT && last_byte_read) begin
        lk_ready <= 1'b0;
      end
      // Count moves only at search end, so software can read it at leisure
      if (state == ST_END) begin
        lk_count <= scan_count;
      end
    end
  end

  // ==========================================================================
  // Static and multicast control register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_start <= 1'b0;
      st_index <= '0;
      st_spare <= 5'h00;
      st_select <= 1'b0;
      st_read <= 1'b0;
    end else begin
      if (wr_st_idx) begin
        st_index <= reg_wdata[TIDX_W-1:0];
      end
      if (wr_st_low) begin
        st_start <= reg_wdata[START_BIT];
        st_spare <= reg_wdata[6:2];
        st_select <= reg_wdata[SELECT_BIT];
        st_read <= reg_wdata[RD_BIT];
      end else if (st_go) begin
        st_start <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Index registers
  always_ff @(posedge clk) begin
    if (rst) begin
      index_hi <= RST_WORD;
      index_lo <= RST_WORD;
    end else if (reg_wr && hit_index_hi) begin
      // Bits 30:23 are read-only zero; bit 31 is kept as written
      index_hi <= put_byte(index_hi, lane, reg_wdata) & 32'h807F_FFFF;
    end else if (reg_wr && hit_index_lo) begin
      index_lo <= put_byte(index_lo, lane, reg_wdata);
    end
  end

  // ==========================================================================
  // Shared entry words; hardware loads win over a software byte write
  // A multicast read refreshes word two only; the other words keep their bytes
  for (genvar k = 0; k < 4; k++) begin : g_entry
    wire load_all = lk_do_read || scan_hit || (st_do_read && !st_is_mcast);
    wire load_w2 = st_do_read && st_is_mcast && k == 1;
    always_ff @(posedge clk) begin
      if (rst) begin
        entry_word[k] <= RST_WORD;
      end else if (load_all || load_w2) begin
        entry_word[k] <= tp.rdata[ENTRY_W-1-32*k -: 32];
      end else if (reg_wr && hit_entry && entry_sel == 2'(k)) begin
        entry_word[k] <= put_byte(entry_word[k], lane, reg_wdata);
      end
    end
  end

  // ==========================================================================
  // Read data and status outputs
  // busy lags the launch bits by one cycle; it is a status view, not a handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= RST_BYTE;
      reg_rvalid <= 1'b0;
      busy <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= get_byte(read_word, lane);
      end
      busy <= lk_start || st_start;
    end
  end

endmodule

// ==== sim/table_access_chk.sv ====
// Port-level assertions for the forwarding-table access control
module table_access_chk
  import table_access_pkg::*;
#(
  parameter int LK_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Status
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Decodes of launch writes and reads
  wire lk_go = reg_wr && reg_addr == ADDR_LOOKUP_CTRL + 16'h0003 && reg_wdata[START_BIT];
  wire st_go = reg_wr && reg_addr == ADDR_STATIC_CTRL + 16'h0003 && reg_wdata[START_BIT];
  wire lk_rd = reg_rd && reg_addr == ADDR_LOOKUP_CTRL + 16'h0003;
  wire unmapped = reg_addr < ADDR_INDEX_HI || reg_addr > ADDR_ENTRY4_LAST;
  wire rsvd_byte = reg_addr == ADDR_LOOKUP_CTRL + 16'h0002 || reg_addr == ADDR_STATIC_CTRL
    || reg_addr == ADDR_STATIC_CTRL + 16'h0002;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Assertions
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no valid pulse");
  a_no_stray_valid: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("valid pulse without a read");
  a_rdata_hold: assert property (!reg_rvalid && !$past(rst) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  // Ignored double launches are never issued by the bench, so the antecedent stays clean
  a_lookup_one_shot: assert property (lk_go && reg_wdata[1:0] != 2'h3
    |-> ##2 busy ##1 !busy)
    else $error("lookup access did not finish in one cycle");
  a_static_one_shot: assert property (st_go |-> ##2 busy ##1 !busy)
    else $error("static access did not finish in one cycle");
  a_busy_cause: assert property ($rose(busy) |-> $past(lk_go, 2) || $past(st_go, 2))
    else $error("busy rose without a launch");
  a_search_scans: assert property (lk_go && reg_wdata[1:0] == 2'h3
    |-> ##2 busy [*8])
    else $error("search ended too soon");
  a_flag_combine: assert property (lk_rd |=> reg_rdata[DONE_BIT]
    == (reg_rdata[READY_BIT] || !reg_rdata[START_BIT]))
    else $error("combined flag wrong");
  a_count_top: assert property (reg_rd && reg_addr == ADDR_LOOKUP_CTRL
    |=> reg_rdata[7:6] == 2'h0)
    else $error("bits above the count not zero");
  a_index_width: assert property (reg_rd && reg_addr == ADDR_STATIC_CTRL + 16'h0001
    |=> reg_rdata[7:6] == 2'h0)
    else $error("bits above the table index not zero");
  a_rsvd_zero: assert property (reg_rd && (rsvd_byte || unmapped)
    |=> reg_rdata == 8'h00)
    else $error("reserved or unmapped byte not zero");
endmodule

bind table_access_ctrl table_access_chk #(.LK_DEPTH(LK_DEPTH)) chk_u (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .busy(busy));

// ==== sim/address_table_access_control_tb_top.sv ====
// Self-checking bench for the forwarding-table access control
module address_table_access_control_tb_top import table_access_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [127:0] ENT_A = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [127:0] ENT_B = 128'h8000_0001_5A5A_A5A5_0F0F_F0F0_1234_5678;
  localparam logic [127:0] ENT_C = 128'hC0DE_0001_0002_0003_0004_0005_0006_0007;
  localparam logic [127:0] ENT_D = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic busy;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  table_access_ctrl #(.LK_DEPTH(16)) dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .busy(busy));
  // ==========================================================================
  // Bus tasks
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One idle cycle between strobes keeps each strobe assigned once per step
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd8(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
  task automatic wrn(input logic [15:0] a, input logic [127:0] v, input int n);
    for (int i = 0; i < n; i++) wr8(a + 16'(i), v[8*(n-1-i) +: 8]);
  endtask
  task automatic rdn(input logic [15:0] a, input int n, output logic [127:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < n; i++) begin
      rd8(a + 16'(i), b);
      v = {v[119:0], b};
    end
  endtask
  // Launch through the control byte, poll until the start bit self-clears
  task automatic launch(input logic [15:0] a, input logic [7:0] d, output logic [7:0] b);
    wr8(a, d);
    for (int i = 0; i < 50; i++) begin
      rd8(a, b);
      if (b[START_BIT] === 1'b0) break;
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic [127:0] v;
    rdn(ADDR_INDEX_HI, 16, v);
    chk(v, 128'h20_0000_0000);
    rdn(ADDR_ENTRY1, 16, v);
    chk(v, '0);
    wr8(16'h0430, 8'hFF);
    rdn(16'h0430, 1, v);
    chk(v, '0);
  endtask
  task automatic t_lookup();
    logic [127:0] v;
    logic [7:0] b;
    wrn(ADDR_INDEX_LO, 128'h3, 4);
    wrn(ADDR_ENTRY1, ENT_A, 16);
    launch(ADDR_LOOKUP_CTRL + 16'h3, 8'h85, b);
    chk({120'h0, b}, 128'h25);
    wrn(ADDR_ENTRY1, '0, 16);
    launch(ADDR_LOOKUP_CTRL + 16'h3, 8'h82, b);
    chk({120'h0, b}, 128'h22);
    rdn(ADDR_ENTRY1, 16, v);
    chk(v, ENT_A);
    wrn(ADDR_INDEX_LO, 128'h5, 4);
    wrn(ADDR_ENTRY1, ENT_B, 16);
    launch(ADDR_LOOKUP_CTRL + 16'h3, 8'h85, b);
    launch(ADDR_LOOKUP_CTRL + 16'h3, 8'h80, b);
    chk({120'h0, b}, 128'h20);
    rdn(ADDR_ENTRY1, 16, v);
    chk(v, ENT_B);
  endtask
  task automatic t_search();
    logic [127:0] v;
    logic [7:0] b;
    int k;
    k = 0;
    wr8(ADDR_LOOKUP_CTRL + 16'h3, 8'h83);
    for (int i = 0; i < 100; i++) begin
      rd8(ADDR_LOOKUP_CTRL + 16'h3, b);
      if (b[READY_BIT] === 1'b1) begin
        rdn(ADDR_ENTRY1, 16, v);
        chk(v, (k == 0) ? ENT_A : ENT_B);
        k++;
        repeat (2) @(negedge clk);
      end else if (b[START_BIT] !== 1'b1) begin
        break;
      end
    end
    chk(128'(k), 128'h2);
    rdn(ADDR_LOOKUP_CTRL, 4, v);
    chk(v, 128'h0002_0023);
  endtask
  task automatic t_hash();
    logic [127:0] v;
    logic [7:0] b;
    wrn(ADDR_INDEX_HI, 128'hFFFF_1234, 4);
    rdn(ADDR_INDEX_HI, 4, v);
    chk(v, 128'h807F_1234);
    wrn(ADDR_INDEX_LO, 128'h89AB_CDEF, 4);
    wrn(ADDR_ENTRY1, ENT_D, 16);
    launch(ADDR_LOOKUP_CTRL + 16'h3, 8'h81, b);
    chk({120'h0, b}, 128'h21);
    wrn(ADDR_ENTRY1, '0, 16);
    launch(ADDR_LOOKUP_CTRL + 16'h3, 8'h82, b);
    chk({120'h0, b}, 128'h22);
    rdn(ADDR_ENTRY1, 16, v);
    chk(v, ENT_D);
  endtask
  task automatic t_static();
    logic [127:0] v;
    logic [7:0] b;
    wr8(ADDR_STATIC_CTRL + 16'h1, 8'h05);
    wrn(ADDR_ENTRY1, ENT_C, 16);
    launch(ADDR_STATIC_CTRL + 16'h3, 8'h80, b);
    chk({120'h0, b}, 128'h00);
    wr8(ADDR_STATIC_CTRL + 16'h1, 8'h25);
    wrn(ADDR_ENTRY1, ENT_D, 16);
    launch(ADDR_STATIC_CTRL + 16'h3, 8'h82, b);
    chk({120'h0, b}, 128'h02);
    wrn(ADDR_ENTRY1, '0, 16);
    launch(ADDR_STATIC_CTRL + 16'h3, 8'h81, b);
    chk({120'h0, b}, 128'h01);
    rdn(ADDR_ENTRY1, 16, v);
    chk(v, ENT_C);
    wrn(ADDR_ENTRY1, '0, 16);
    launch(ADDR_STATIC_CTRL + 16'h3, 8'h83, b);
    rdn(ADDR_ENTRY1, 16, v);
    chk(v, {32'h0, ENT_D[95:64], 64'h0});
    rdn(ADDR_STATIC_CTRL, 4, v);
    chk(v, 128'h0025_0003);
  endtask
  // ==========================================================================
  // Verdict and watchdog
  task automatic final_report();
    if (miscompares == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_lookup();
    t_search();
    t_hash();
    t_static();
    final_report();
  end
endmodule
